// ===== logic/rsw_debounce.sv
// pushbutton debouncer for the reset supervisor
// assumes level_n is already synchronised to mclk
`timescale 1ns/1ps
`include "rsw_regs.svh"

module rsw_debounce #(
  parameter logic [31:0] DEB_CYC = `RSW_PB_DEB_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic level_n,
  output logic pressed
);

  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic pressed_r;
  logic pressed_nxt;
  wire at_limit = (cnt_r >= DEB_CYC - 32'h1);

  // any high sample restarts the count, so bounces never add up
  assign cnt_nxt = level_n ? 32'h0 : (at_limit ? cnt_r : cnt_r + 32'h1);
  assign pressed_nxt = ~level_n & (pressed_r | at_limit);
  assign pressed = pressed_r;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 32'h0;
      pressed_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      pressed_r <= pressed_nxt;
    end
  end

  a_press_needs_time: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $rose(pressed_r) |-> ($past(cnt_r) >= DEB_CYC - 32'h1) && !$past(level_n))
    else $error("press flagged before the debounce time ran out");

  a_release_drops: assert property (
    @(posedge mclk) disable iff (!rst_b)
    level_n |=> !pressed_r)
    else $error("press flag stayed up after the input went high");

endmodule : rsw_debounce

// ===== logic/rsw_pkg.sv
// types shared by the reset supervisor files
// assumes the timing header is included by the modules that need counts
package rsw_pkg;

  // three-state watchdog period select, decoded from the strap pin
  typedef enum logic [1:0] {
    RSW_TD_LOW = 2'b00,
    RSW_TD_OPEN = 2'b01,
    RSW_TD_HIGH = 2'b10
  } rsw_tdsel_t;

  typedef enum logic [1:0] {
    RSW_ST_RUN = 2'b00,
    RSW_ST_ASSERT = 2'b01,
    RSW_ST_HOLD = 2'b10
  } rsw_state_t;

  // which source caused the most recent reset
  typedef struct packed {
    logic supply;
    logic manual;
    logic watchdog;
  } rsw_cause_t;

endpackage : rsw_pkg

// ===== logic/rsw_regs.svh
// timing constants for the reset supervisor with watchdog
// assumes a 200 MHz mclk; counts are derived from times below
`ifndef RSW_REGS_SVH
`define RSW_REGS_SVH

// clock rate in kHz, so that a time in ms times this gives cycles
`define RSW_CLK_KHZ 200000
`define RSW_CLK_MHZ 200

// pushbutton debounce time, between the 1 ms and 20 ms limits
`define RSW_PB_DEB_US 4000
`define RSW_PB_DEB_CYC (`RSW_PB_DEB_US * `RSW_CLK_MHZ)

// reset active time, typical figure
`define RSW_RST_HOLD_MS 610
`define RSW_RST_HOLD_CYC (`RSW_RST_HOLD_MS * `RSW_CLK_KHZ)

// watchdog periods, nominal figures per select level
`define RSW_WD_LOW_MS 150
`define RSW_WD_OPEN_MS 600
`define RSW_WD_HIGH_MS 1200
`define RSW_WD_LOW_CYC (`RSW_WD_LOW_MS * `RSW_CLK_KHZ)
`define RSW_WD_OPEN_CYC (`RSW_WD_OPEN_MS * `RSW_CLK_KHZ)
`define RSW_WD_HIGH_CYC (`RSW_WD_HIGH_MS * `RSW_CLK_KHZ)

// longest supply-fail latency allowed, and its cycle count
`define RSW_SUPPLY_LAT_NS 8000
`define RSW_SUPPLY_LAT_CYC (`RSW_SUPPLY_LAT_NS * `RSW_CLK_MHZ / 1000)

`endif

// ===== logic/rsw_top.sv
// reset supervisor: supply monitor, watchdog and pushbutton reset
// assumes supply_low comes from an analog comparator on no clock, and
// all pins are asynchronous to mclk; mclk runs free from power-up
`timescale 1ns/1ps
`include "rsw_regs.svh"

module rsw_top #(
  parameter logic [31:0] PB_DEB_CYC = `RSW_PB_DEB_CYC,
  parameter logic [31:0] RST_HOLD_CYC = `RSW_RST_HOLD_CYC,
  parameter logic [31:0] WD_LOW_CYC = `RSW_WD_LOW_CYC,
  parameter logic [31:0] WD_OPEN_CYC = `RSW_WD_OPEN_CYC,
  parameter logic [31:0] WD_HIGH_CYC = `RSW_WD_HIGH_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic supply_low,
  input wire logic manual_reset_n,
  input wire logic watchdog_kick_n,
  input wire rsw_pkg::rsw_tdsel_t timeout_select,
  input wire logic threshold_select,
  input wire logic reset_line_i,
  output logic reset_line_o,
  output logic reset_line_oe,
  output logic reset_out,
  output logic threshold_high_tol,
  output rsw_pkg::rsw_cause_t last_cause
);
  import rsw_pkg::*;

  // watchdog limit for a select code; an undefined code counts as open
  function automatic logic [31:0] wd_limit(input logic [1:0] sel,
                                           input logic [31:0] lo,
                                           input logic [31:0] op,
                                           input logic [31:0] hi);
    logic [31:0] val;
    val = op;
    case (sel)
      RSW_TD_LOW: val = lo;
      RSW_TD_OPEN: val = op;
      RSW_TD_HIGH: val = hi;
      default: val = op;
    endcase
    return val;
  endfunction : wd_limit

  // two-flop synchronisers for every input pin except reset_line_i, which is unused
  logic supply_s1_r;
  logic supply_s2_r;
  logic manual_s1_r;
  logic manual_s2_r;
  logic kick_s1_r;
  logic kick_s2_r;
  logic kick_s3_r;
  logic [1:0] tdsel_s1_r;
  logic [1:0] tdsel_s2_r;
  logic [1:0] tdsel_s3_r;
  logic [1:0] tdsel_r;
  logic [1:0] tdsel_nxt;
  logic tol_s1_r;
  logic tol_s2_r;

  // the two select bits may settle on different edges; a code is only
  // taken once seen twice, so a passing code never picks the period
  assign tdsel_nxt = (tdsel_s2_r == tdsel_s3_r) ? tdsel_s2_r : tdsel_r;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      supply_s1_r <= 1'b0;
      supply_s2_r <= 1'b0;
      manual_s1_r <= 1'b1;
      manual_s2_r <= 1'b1;
      kick_s1_r <= 1'b1;
      kick_s2_r <= 1'b1;
      kick_s3_r <= 1'b1;
      tdsel_s1_r <= 2'h0;
      tdsel_s2_r <= 2'h0;
      tdsel_s3_r <= 2'h0;
      tdsel_r <= 2'h0;
      tol_s1_r <= 1'b0;
      tol_s2_r <= 1'b0;
    end else begin
      supply_s1_r <= supply_low;
      supply_s2_r <= supply_s1_r;
      manual_s1_r <= manual_reset_n;
      manual_s2_r <= manual_s1_r;
      kick_s1_r <= watchdog_kick_n;
      kick_s2_r <= kick_s1_r;
      kick_s3_r <= kick_s2_r;
      tdsel_s1_r <= timeout_select;
      tdsel_s2_r <= tdsel_s1_r;
      tdsel_s3_r <= tdsel_s2_r;
      tdsel_r <= tdsel_nxt;
      tol_s1_r <= threshold_select;
      tol_s2_r <= tol_s1_r;
    end
  end

  // a 20 ns low strobe spans at least three mclk edges, so it always
  // survives the synchroniser; edge is taken past the second flop
  wire kick_fall = kick_s3_r & ~kick_s2_r;

  logic manual_pressed;

  rsw_debounce #(
    .DEB_CYC(PB_DEB_CYC)
  ) u_debounce (
    .mclk(mclk),
    .rst_b(rst_b),
    .level_n(manual_s2_r),
    .pressed(manual_pressed)
  );

  // sequencer state and counters
  rsw_state_t state_r;
  rsw_state_t state_nxt;
  logic [31:0] wd_cnt_r;
  logic [31:0] wd_cnt_nxt;
  logic [31:0] hold_cnt_r;
  logic [31:0] hold_cnt_nxt;
  logic reset_out_r;
  logic reset_oe_r;
  logic tol_r;
  rsw_cause_t cause_r;
  rsw_cause_t cause_nxt;
  rsw_cause_t cause_now;

  wire [31:0] wd_lim = wd_limit(tdsel_r, WD_LOW_CYC, WD_OPEN_CYC, WD_HIGH_CYC);
  wire in_run = (state_r == RSW_ST_RUN);
  // compare with >= so a shorter period picked mid-count still expires
  wire wd_expire = in_run & ~kick_fall & (wd_cnt_r >= wd_lim - 32'h1);
  wire level_cause = supply_s2_r | manual_pressed;
  wire hold_done = (hold_cnt_r >= RST_HOLD_CYC - 32'h1);
  wire new_cause = level_cause | wd_expire;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RSW_ST_RUN: begin
        if (new_cause) begin
          state_nxt = RSW_ST_ASSERT;
        end
      end
      RSW_ST_ASSERT: begin
        if (!level_cause) begin
          state_nxt = RSW_ST_HOLD;
        end
      end
      RSW_ST_HOLD: begin
        if (level_cause) begin
          state_nxt = RSW_ST_ASSERT;
        end else if (hold_done) begin
          state_nxt = RSW_ST_RUN;
        end
      end
      default: begin
        state_nxt = RSW_ST_HOLD;
      end
    endcase
  end

  // hold count restarts whenever a cause is still present
  assign hold_cnt_nxt = (state_nxt == RSW_ST_HOLD && state_r == RSW_ST_HOLD)
                        ? hold_cnt_r + 32'h1 : 32'h0;

  // watchdog idles at zero outside run, so release starts a full period
  // the release cycle itself loads zero, else the first period runs short
  assign wd_cnt_nxt = (!in_run || state_nxt != RSW_ST_RUN) ? 32'h0 :
                      (kick_fall ? 32'h0 : wd_cnt_r + 32'h1);

  // cause record is overwritten on every fresh assertion
  assign cause_now = {supply_s2_r, manual_pressed, wd_expire};
  assign cause_nxt = (state_nxt == RSW_ST_ASSERT && state_r != RSW_ST_ASSERT)
                     ? cause_now : cause_r;

  // power-up enters hold, so the outputs stay asserted for one period
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= RSW_ST_HOLD;
      wd_cnt_r <= 32'h0;
      hold_cnt_r <= 32'h0;
      cause_r <= '0;
    end else begin
      state_r <= state_nxt;
      wd_cnt_r <= wd_cnt_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      cause_r <= cause_nxt;
    end
  end

  // both resets come from one next-state term, one flop each
  wire reset_nxt = (state_nxt != RSW_ST_RUN);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reset_out_r <= 1'b1;
      reset_oe_r <= 1'b1;
      tol_r <= 1'b0;
    end else begin
      reset_out_r <= reset_nxt;
      reset_oe_r <= reset_nxt;
      tol_r <= tol_s2_r;
    end
  end

  // open drain: the pin is only ever pulled low, never driven high
  assign reset_line_o = 1'b0;
  assign reset_line_oe = reset_oe_r;
  assign reset_out = reset_out_r;
  assign threshold_high_tol = tol_r;
  assign last_cause = cause_r;

  a_supply_latency: assert property (
    @(posedge mclk) disable iff (!rst_b)
    supply_s2_r |=> reset_out_r && reset_oe_r)
    else $error("reset not asserted one cycle after supply fail");

  a_outputs_compl: assert property (
    @(posedge mclk) disable iff (!rst_b)
    reset_out_r == reset_oe_r)
    else $error("reset outputs disagree");

  a_line_open_drain: assert property (
    @(posedge mclk) disable iff (!rst_b)
    reset_line_o == 1'b0)
    else $error("open-drain reset line driven high");

  a_button_forces: assert property (
    @(posedge mclk) disable iff (!rst_b)
    manual_pressed |=> reset_out_r)
    else $error("debounced button did not assert reset");

  a_hold_full: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $fell(reset_out_r) |-> $past(hold_cnt_r) == RST_HOLD_CYC - 32'h1
                          && $past(state_r) == RSW_ST_HOLD)
    else $error("reset released before the active time ran out");

  a_hold_after_cause: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $fell(level_cause) |-> reset_out_r ##1 (reset_out_r && hold_cnt_r == 32'h0))
    else $error("hold period not started when the cause ended");

  a_wd_expiry: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (in_run && !kick_fall && wd_cnt_r == wd_lim - 32'h1) |=> reset_out_r)
    else $error("watchdog period passed without asserting reset");

  a_wd_period: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $rose(reset_out_r) && $past(wd_expire) |->
      $past(wd_cnt_r) >= wd_limit($past(tdsel_r), WD_LOW_CYC, WD_OPEN_CYC,
                                  WD_HIGH_CYC) - 32'h1)
    else $error("watchdog expired early for the selected period");

  a_kick_restart: assert property (
    @(posedge mclk) disable iff (!rst_b)
    kick_fall |=> wd_cnt_r == 32'h0 && !$past(wd_expire))
    else $error("strobe edge did not restart the watchdog");

  a_wd_cleared: assert property (
    @(posedge mclk) disable iff (!rst_b)
    reset_out_r |-> wd_cnt_r == 32'h0)
    else $error("watchdog counting while reset is asserted");

  a_tol_follow: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ##1 threshold_high_tol == $past(tol_s2_r))
    else $error("threshold select not passed to the comparator");

  a_fresh_period: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $fell(reset_out_r) |-> wd_cnt_r == 32'h0)
    else $error("watchdog period not restarted at release");

  a_hold_restart: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (state_r == RSW_ST_HOLD && level_cause) |=> reset_out_r && hold_cnt_r == 32'h0)
    else $error("cause during hold did not restart the hold period");

  a_cause_record: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $rose(reset_out_r) |-> cause_r != 3'h0)
    else $error("reset asserted with no cause recorded");

  a_hold_bound: assert property (
    @(posedge mclk) disable iff (!rst_b)
    hold_cnt_r < RST_HOLD_CYC)
    else $error("hold count ran past the reset active time");

endmodule : rsw_top

// ===== testbench/rsw_host_model.sv
// host and pushbutton model facing the reset supervisor
// assumes mclk is the supervisor clock; requests come from tb_top
`timescale 1ns/1ps

module rsw_host_model (
  input wire logic mclk,
  input wire logic kick_en,
  input wire logic [7:0] kick_gap,
  input wire logic press_req,
  output logic watchdog_kick_n,
  output logic manual_reset_n
);
  logic [7:0] gap_r = 8'hFF;
  logic kick_r = 1'b1;
  logic en_seen;

  // released button rests high through the pull-up
  assign manual_reset_n = ~press_req;
  assign watchdog_kick_n = kick_r;

  // low of 4 cycles, 20 ns; a low already begun runs out before the
  // strobe parks, so no kick falls below the minimum width
  // enable is taken at the edge, clear of the bench's own drive time
  always @(posedge mclk) begin
    en_seen = kick_en;
    #1;
    if (en_seen || gap_r < 8'h03) begin
      gap_r = (gap_r >= kick_gap - 8'h01) ? 8'h00 : gap_r + 8'h01;
    end else begin
      gap_r = 8'hFF;
    end
    kick_r = (gap_r < 8'h04) ? 1'b0 : 1'b1;
  end
endmodule : rsw_host_model

// ===== testbench/tb_top.sv
// self-checking bench for the reset supervisor with watchdog
// assumes shortened counts; the host model kicks and presses
`timescale 1ns/1ps

module tb_top;
  import rsw_pkg::*;
  localparam int HOLD = 20;
  localparam int DEB = 8;
  // last entry is the undefined select code, read as open
  localparam int WD [4] = '{40, 60, 80, 60};
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic supply_low = 1'b0;
  logic threshold_select = 1'b0;
  logic kick_en = 1'b1;
  logic press_req = 1'b0;
  rsw_tdsel_t tdsel = RSW_TD_LOW;
  logic manual_reset_n, watchdog_kick_n, reset_line_o, reset_line_oe, reset_out, thr_tol;
  rsw_cause_t last_cause;
  int fails = 0;
  int checked = 0;
  int n;

  always #2.5 mclk = ~mclk;

  rsw_top #(.PB_DEB_CYC(DEB), .RST_HOLD_CYC(HOLD), .WD_LOW_CYC(WD[0]),
    .WD_OPEN_CYC(WD[1]), .WD_HIGH_CYC(WD[2])) rsw_top_inst (
    .mclk(mclk), .rst_b(rst_b), .supply_low(supply_low),
    .manual_reset_n(manual_reset_n), .watchdog_kick_n(watchdog_kick_n),
    .timeout_select(tdsel), .threshold_select(threshold_select),
    .reset_line_i(reset_line_oe ? 1'b0 : 1'b1), .reset_line_o(reset_line_o),
    .reset_line_oe(reset_line_oe), .reset_out(reset_out),
    .threshold_high_tol(thr_tol), .last_cause(last_cause));

  rsw_host_model rsw_host_model_inst (
    .mclk(mclk), .kick_en(kick_en), .kick_gap(8'h1E), .press_req(press_req),
    .watchdog_kick_n(watchdog_kick_n), .manual_reset_n(manual_reset_n));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic step(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask : step

  // bounded wait for reset_out, cycles counted in n
  task automatic wait_out(input logic val, input int max);
    n = 0;
    while (reset_out !== val) begin
      step(1);
      n++;
      if (n > max) begin
        check("reset wait", reset_out, val);
        report_and_stop();
      end
    end
  endtask : wait_out

  task automatic quiet(input int cyc);
    int hits;
    hits = 0;
    repeat (cyc) begin
      step(1);
      if (reset_out !== 1'b0) hits++;
    end
    check("quiet", hits, 0);
  endtask : quiet

  // pin pair checked every cycle, reset included
  always @(negedge mclk) begin
    check("oe", reset_line_oe, reset_out);
    check("drain", reset_line_o, 0);
  end

  task automatic por_hold;
    step(16);
    check("por out", reset_out, 1);
    rst_b = 1'b1;
    wait_out(1'b0, HOLD + 10);
    check("por hold", n >= HOLD, 1);
  endtask : por_hold

  task automatic supply_fail;
    supply_low = 1'b1;
    step(2);
    check("supply early", reset_out, 0);
    step(1);
    check("supply late", reset_out, 1);
    check("supply cause", last_cause, 3'h4);
    step(10);
    supply_low = 1'b0;
    step(10);
    check("supply mid hold", reset_out, 1);
    // a short dip during hold must restart the whole hold period
    supply_low = 1'b1;
    step(1);
    supply_low = 1'b0;
    wait_out(1'b0, HOLD + 10);
    check("supply hold", n >= HOLD && n <= HOLD + 6, 1);
  endtask : supply_fail

  task automatic tol_select;
    threshold_select = 1'b1;
    step(4);
    check("tol high", thr_tol, 1);
    threshold_select = 1'b0;
    step(4);
    check("tol low", thr_tol, 0);
  endtask : tol_select

  // a short glitch first, then a press well past the debounce time
  task automatic button;
    press_req = 1'b1;
    step(DEB - 3);
    press_req = 1'b0;
    quiet(DEB + 8);
    press_req = 1'b1;
    wait_out(1'b1, DEB + 8);
    check("button cause", last_cause, 3'h2);
    step(3 * DEB);
    check("button held", reset_out, 1);
    press_req = 1'b0;
    wait_out(1'b0, HOLD + 10);
    check("button hold", n >= HOLD, 1);
  endtask : button

  // second expiry timed from release, so the period starts clean
  task automatic watchdog;
    for (int i = 0; i < 4; i++) begin
      tdsel = rsw_tdsel_t'(i);
      kick_en = 1'b0;
      wait_out(1'b1, WD[i] + 10);
      wait_out(1'b0, HOLD + 10);
      wait_out(1'b1, WD[i] + 10);
      check("wd period", n >= WD[i] - 1 && n <= WD[i] + 2, 1);
      check("wd cause", last_cause, 3'h1);
      kick_en = 1'b1;
      wait_out(1'b0, HOLD + 10);
      quiet(3 * WD[i]);
    end
  endtask : watchdog

  initial begin
    por_hold();
    supply_fail();
    tol_select();
    button();
    watchdog();
    report_and_stop();
  end
endmodule : tb_top
